// >>> rtl/igp_pkg.sv
package igp_pkg;
   // ------------------------------------------------------------------
   // address map
   // ------------------------------------------------------------------
   localparam int IGP_NPORTS = 3;
   localparam int IGP_W0 = 11;
   localparam int IGP_W1 = 15;
   localparam int IGP_W2 = 16;
   localparam int IGP_PINS = IGP_W0 + IGP_W1 + IGP_W2;
   localparam int IGP_LSB1 = IGP_W0;
   localparam int IGP_LSB2 = IGP_W0 + IGP_W1;
   // port bases are word indices; byte address is four times the index
   localparam logic [15:0] IGP_BASE0 = 16'hfca0;
   localparam logic [15:0] IGP_BASE1 = 16'hfcc0;
   localparam logic [15:0] IGP_BASE2 = 16'hfce0;
   localparam int IGP_BLK_LSB = 5;
   localparam int IGP_ADR_W = 18;

   // ------------------------------------------------------------------
   // register indices within one port
   // ------------------------------------------------------------------
   localparam logic [3:0] IGP_PIN_DIRECTION = 4'h0;
   localparam logic [3:0] IGP_OUTPUT_VALUE = 4'h1;
   localparam logic [3:0] IGP_PIN_LEVEL = 4'h2;
   localparam logic [3:0] IGP_FALL_IRQ_ENABLE = 4'h3;
   localparam logic [3:0] IGP_RISE_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] IGP_EDGE_PENDING = 4'h5;
   localparam logic [3:0] IGP_OUTPUT_SET_STROBE = 4'h6;
   localparam logic [3:0] IGP_OUTPUT_CLEAR_STROBE = 4'h7;
   localparam logic [3:0] IGP_BITMAP_CONFIG = 4'h8;
   localparam logic [3:0] IGP_SINGLE_BIT_ACCESS_A = 4'h9;
   localparam logic [3:0] IGP_SINGLE_BIT_ACCESS_B = 4'ha;
   localparam logic [3:0] IGP_PERIPHERAL_SELECT = 4'hb;
   localparam logic [3:0] IGP_IRQ_MASK = 4'hc;
   localparam logic [3:0] IGP_REG_LAST = 4'hc;

   // ------------------------------------------------------------------
   // bitmap_config fields and reset values
   // ------------------------------------------------------------------
   localparam int IGP_B_DAT_LSB = 12;
   localparam int IGP_B_PIN_LSB = 8;
   localparam int IGP_A_DAT_LSB = 4;
   localparam int IGP_A_PIN_LSB = 0;
   localparam logic [15:0] IGP_RST_VAL = 16'h0000;
   localparam logic [15:0] IGP_MASK_RST = 16'h0000;
endpackage : igp_pkg

// >>> rtl/igp_top.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// one port
// ----------------------------------------------------------------------
module igp_port #(
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [3:0] idx_i,
   input wire logic [15:0] wdat_i,
   input wire logic [15:0] wmask_i,
   output logic [15:0] rdat_o,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_o,
   output logic [WIDTH-1:0] pin_oe_o,
   input wire logic [WIDTH-1:0] periph_out_i,
   input wire logic [WIDTH-1:0] periph_oe_i,
   output logic [WIDTH-1:0] periph_sel_o,
   output logic irq_req_o,
   output logic irq_masked_o
);
   import igp_pkg::*;

   // bits above the port width have no pin and read as zero, except in bitmap_config and the single-bit access reads
   localparam logic [31:0] VFULL = (32'h1 << WIDTH) - 32'h1;
   localparam logic [15:0] VMASK = VFULL[15:0];

   logic [15:0] dir, outv, fall_en, rise_en, pend, conf, psel, imask;
   logic [15:0] sync1, level, level_q;
   logic [15:0] pin16, rise_hit, fall_hit, edge_hit;
   logic [15:0] wd, next_dir, next_outv, next_pend;
   logic [15:0] eng_a_rd, eng_b_rd, eng_a_bit, eng_b_bit;
   logic [3:0] a_pin, a_dat, b_pin, b_dat;
   logic w_dir, w_out, w_fall, w_rise, w_pend, w_set, w_clr;
   logic w_conf, w_eng_a, w_eng_b, w_psel, w_mask;

   // ------------------------------------------------------------------
   // write strobes and data
   // ------------------------------------------------------------------
   assign wd = wdat_i & wmask_i & VMASK;
   assign w_dir = wr_i && idx_i == IGP_PIN_DIRECTION;
   assign w_out = wr_i && idx_i == IGP_OUTPUT_VALUE;
   assign w_fall = wr_i && idx_i == IGP_FALL_IRQ_ENABLE;
   assign w_rise = wr_i && idx_i == IGP_RISE_IRQ_ENABLE;
   assign w_pend = wr_i && idx_i == IGP_EDGE_PENDING;
   assign w_set = wr_i && idx_i == IGP_OUTPUT_SET_STROBE;
   assign w_clr = wr_i && idx_i == IGP_OUTPUT_CLEAR_STROBE;
   assign w_conf = wr_i && idx_i == IGP_BITMAP_CONFIG;
   assign w_eng_a = wr_i && idx_i == IGP_SINGLE_BIT_ACCESS_A;
   assign w_eng_b = wr_i && idx_i == IGP_SINGLE_BIT_ACCESS_B;
   assign w_psel = wr_i && idx_i == IGP_PERIPHERAL_SELECT;
   assign w_mask = wr_i && idx_i == IGP_IRQ_MASK;

   // ------------------------------------------------------------------
   // bit engines
   // ------------------------------------------------------------------
   assign a_pin = conf[IGP_A_PIN_LSB +: 4];
   assign a_dat = conf[IGP_A_DAT_LSB +: 4];
   assign b_pin = conf[IGP_B_PIN_LSB +: 4];
   assign b_dat = conf[IGP_B_DAT_LSB +: 4];
   // a pin index beyond the width selects nothing
   assign eng_a_bit = (16'h1 << a_pin) & VMASK;
   assign eng_b_bit = (16'h1 << b_pin) & VMASK;
   assign eng_a_rd = {15'h0, level[a_pin]} << a_dat;
   assign eng_b_rd = {15'h0, level[b_pin]} << b_dat;

   // output value: plain write, strobes, then engines; one per cycle
   always_comb begin
      next_outv = outv;
      if (w_out) begin
         next_outv = (outv & ~wmask_i) | wd;
      end else if (w_set) begin
         next_outv = outv | wd;
      end else if (w_clr) begin
         next_outv = outv & ~wd;
      end else if (w_eng_a && wmask_i != 16'h0) begin
         next_outv = wdat_i[a_dat] ? outv | eng_a_bit
                                   : outv & ~eng_a_bit;
      end else if (w_eng_b && wmask_i != 16'h0) begin
         next_outv = wdat_i[b_dat] ? outv | eng_b_bit
                                   : outv & ~eng_b_bit;
      end
   end

   assign next_dir = (dir & ~wmask_i) | wd;

   // ------------------------------------------------------------------
   // pin sampling and edge capture
   // ------------------------------------------------------------------
   assign pin16 = 16'(pin_i);
   assign rise_hit = level & ~level_q & rise_en;
   assign fall_hit = ~level & level_q & fall_en;
   assign edge_hit = (rise_hit | fall_hit) & VMASK;
   // an edge in the clearing cycle survives: set wins over clear
   assign next_pend = (pend & ~(w_pend ? wd : 16'h0)) | edge_hit;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= IGP_RST_VAL;
         level <= IGP_RST_VAL;
         level_q <= IGP_RST_VAL;
      end else begin
         sync1 <= pin16;
         level <= sync1;
         level_q <= level;
      end
   end

   // configuration and status registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir <= IGP_RST_VAL;
         outv <= IGP_RST_VAL;
         fall_en <= IGP_RST_VAL;
         rise_en <= IGP_RST_VAL;
         pend <= IGP_RST_VAL;
         conf <= IGP_RST_VAL;
         psel <= IGP_RST_VAL;
         imask <= IGP_MASK_RST;
      end else begin
         if (w_dir) dir <= next_dir;
         if (w_fall) fall_en <= (fall_en & ~wmask_i) | wd;
         if (w_rise) rise_en <= (rise_en & ~wmask_i) | wd;
         if (w_conf) conf <= (conf & ~wmask_i) | (wdat_i & wmask_i);
         if (w_psel) psel <= (psel & ~wmask_i) | wd;
         if (w_mask) imask <= (imask & ~wmask_i) | wd;
         outv <= next_outv;
         pend <= next_pend;
      end
   end

   // ------------------------------------------------------------------
   // pins, interrupts, read mux
   // ------------------------------------------------------------------
   // peripheral owns the pin while its select bit is set
   assign pin_o = (psel[WIDTH-1:0] & periph_out_i)
                  | (~psel[WIDTH-1:0] & outv[WIDTH-1:0]);
   assign pin_oe_o = (psel[WIDTH-1:0] & periph_oe_i)
                     | (~psel[WIDTH-1:0] & dir[WIDTH-1:0]);
   assign periph_sel_o = psel[WIDTH-1:0];
   assign irq_req_o = pend != 16'h0;
   assign irq_masked_o = (pend & imask) != 16'h0;

   always_comb begin
      case (idx_i)
         IGP_PIN_DIRECTION: rdat_o = dir;
         IGP_OUTPUT_VALUE: rdat_o = outv;
         IGP_PIN_LEVEL: rdat_o = level;
         IGP_FALL_IRQ_ENABLE: rdat_o = fall_en;
         IGP_RISE_IRQ_ENABLE: rdat_o = rise_en;
         IGP_EDGE_PENDING: rdat_o = pend;
         IGP_BITMAP_CONFIG: rdat_o = conf;
         IGP_SINGLE_BIT_ACCESS_A: rdat_o = eng_a_rd;
         IGP_SINGLE_BIT_ACCESS_B: rdat_o = eng_b_rd;
         IGP_PERIPHERAL_SELECT: rdat_o = psel;
         IGP_IRQ_MASK: rdat_o = imask;
         default: rdat_o = 16'h0; // strobes are write only
      endcase
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   dir_reset_a: assert property (@(posedge clk_i)
      $past(rst_i) |-> dir == 16'h0 && pin_oe_o == '0)
      else $error("direction not cleared by reset");
   rise_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rise_hit != 16'h0) |=> (pend & $past(rise_hit)) == $past(rise_hit))
      else $error("rising edge lost");
   fall_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (fall_hit != 16'h0) |=> (pend & $past(fall_hit)) == $past(fall_hit))
      else $error("falling edge lost");
   irq_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_req_o) |-> $past(edge_hit) != 16'h0)
      else $error("request rose without an edge");
   irq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_req_o && !w_pend |=> irq_req_o)
      else $error("request dropped with bits pending");
   clear_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_pend |=> ((($past(pend) & ~$past(wd)) & ~pend) == 16'h0)
         && ((pend & $past(wd) & ~$past(edge_hit)) == 16'h0))
      else $error("pending clear hit wrong bits");
   set_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_set |=> outv == ($past(outv) | $past(wd)))
      else $error("set strobe wrong");
   clr_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_clr |=> outv == ($past(outv) & ~$past(wd)))
      else $error("clear strobe wrong");
   level_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(rst_i, 2) |-> level == $past(pin16, 2))
      else $error("pin level not two samples late");
   pin_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((pin_oe_o & ~psel[WIDTH-1:0]) ^ dir[WIDTH-1:0]
         & ~psel[WIDTH-1:0]) == '0)
      else $error("gpio enable does not follow direction");

   // a selected pin is wholly the peripheral's, value and enable
   psel_owner_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((pin_oe_o ^ periph_oe_i) & psel[WIDTH-1:0]) == '0
         && ((pin_o ^ periph_out_i) & psel[WIDTH-1:0]) == '0)
      else $error("peripheral pin not handed over");

   // gpio pins show the output value register
   out_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((pin_o ^ outv[WIDTH-1:0]) & ~psel[WIDTH-1:0]) == '0)
      else $error("gpio pin not driven from output value");

   // a full-word direction write lands as written, cut to the width
   dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_dir && wmask_i == 16'hffff |=> dir == ($past(wdat_i) & VMASK))
      else $error("direction write lost");

   // only a clear write may drop a pending bit
   pend_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !w_pend |=> (pend & $past(pend)) == $past(pend))
      else $error("pending bit dropped without a clear");

   // any captured edge raises the port request next cycle
   edge_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_hit != 16'h0 |=> irq_req_o)
      else $error("edge did not raise the request");

   // engine writes reach the selected output bit
   eng_a_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_eng_a && wmask_i != 16'h0 && a_pin < WIDTH
         |=> outv[$past(a_pin)] == $past(wdat_i[a_dat]))
      else $error("engine a write missed its pin");

   // second engine, same behaviour on its own fields
   eng_b_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_eng_b && wmask_i != 16'h0 && b_pin < WIDTH
         |=> outv[$past(b_pin)] == $past(wdat_i[b_dat]))
      else $error("engine b write missed its pin");
endmodule : igp_port

// ----------------------------------------------------------------------
// wishbone slave and the three ports
// ----------------------------------------------------------------------
module igp_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [igp_pkg::IGP_ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [igp_pkg::IGP_PINS-1:0] pin_i,
   output logic [igp_pkg::IGP_PINS-1:0] pin_o,
   output logic [igp_pkg::IGP_PINS-1:0] pin_oe_o,
   input wire logic [igp_pkg::IGP_PINS-1:0] periph_out_i,
   input wire logic [igp_pkg::IGP_PINS-1:0] periph_oe_i,
   output logic [igp_pkg::IGP_PINS-1:0] periph_sel_o,
   output logic [igp_pkg::IGP_NPORTS-1:0] port_irq_o,
   output logic irq_o
);
   import igp_pkg::*;

   logic [15:0] word_adr, wmask, rmux;
   logic [15:0] rdat0, rdat1, rdat2;
   logic [3:0] reg_idx;
   logic [2:0] hit, wr, masked;
   logic req, reg_ok, wr_go;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   assign word_adr = adr_i[IGP_ADR_W-1:2];
   assign reg_idx = word_adr[3:0];
   assign reg_ok = !word_adr[4] && reg_idx <= IGP_REG_LAST;
   assign hit[0] = word_adr[15:IGP_BLK_LSB] == IGP_BASE0[15:IGP_BLK_LSB];
   assign hit[1] = word_adr[15:IGP_BLK_LSB] == IGP_BASE1[15:IGP_BLK_LSB];
   assign hit[2] = word_adr[15:IGP_BLK_LSB] == IGP_BASE2[15:IGP_BLK_LSB];
   assign req = cyc_i && stb_i;
   // writes land on the edge where the master sees ack
   assign wr_go = req && we_i && ack_o && reg_ok;
   assign wr = wr_go ? hit : 3'h0;
   assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   // unmapped or out-of-range words read as zero and still ack
   assign rmux = !reg_ok ? 16'h0 : hit[0] ? rdat0 : hit[1] ? rdat1 :
                 hit[2] ? rdat2 : 16'h0;
   assign irq_o = masked != 3'h0;

   // single-wait-state answer, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= req && !ack_o;
         if (req && !ack_o) dat_o <= {16'h0, rmux};
      end
   end

   // ------------------------------------------------------------------
   // port instances
   // ------------------------------------------------------------------
   igp_port #(.WIDTH(IGP_W0)) u_port0 (
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr[0]), .idx_i(reg_idx),
      .wdat_i(dat_i[15:0]), .wmask_i(wmask), .rdat_o(rdat0),
      .pin_i(pin_i[IGP_W0-1:0]), .pin_o(pin_o[IGP_W0-1:0]),
      .pin_oe_o(pin_oe_o[IGP_W0-1:0]),
      .periph_out_i(periph_out_i[IGP_W0-1:0]),
      .periph_oe_i(periph_oe_i[IGP_W0-1:0]),
      .periph_sel_o(periph_sel_o[IGP_W0-1:0]),
      .irq_req_o(port_irq_o[0]), .irq_masked_o(masked[0]));
   igp_port #(.WIDTH(IGP_W1)) u_port1 (
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr[1]), .idx_i(reg_idx),
      .wdat_i(dat_i[15:0]), .wmask_i(wmask), .rdat_o(rdat1),
      .pin_i(pin_i[IGP_LSB1 +: IGP_W1]), .pin_o(pin_o[IGP_LSB1 +: IGP_W1]),
      .pin_oe_o(pin_oe_o[IGP_LSB1 +: IGP_W1]),
      .periph_out_i(periph_out_i[IGP_LSB1 +: IGP_W1]),
      .periph_oe_i(periph_oe_i[IGP_LSB1 +: IGP_W1]),
      .periph_sel_o(periph_sel_o[IGP_LSB1 +: IGP_W1]),
      .irq_req_o(port_irq_o[1]), .irq_masked_o(masked[1]));
   igp_port #(.WIDTH(IGP_W2)) u_port2 (
      .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr[2]), .idx_i(reg_idx),
      .wdat_i(dat_i[15:0]), .wmask_i(wmask), .rdat_o(rdat2),
      .pin_i(pin_i[IGP_LSB2 +: IGP_W2]), .pin_o(pin_o[IGP_LSB2 +: IGP_W2]),
      .pin_oe_o(pin_oe_o[IGP_LSB2 +: IGP_W2]),
      .periph_out_i(periph_out_i[IGP_LSB2 +: IGP_W2]),
      .periph_oe_i(periph_oe_i[IGP_LSB2 +: IGP_W2]),
      .periph_sel_o(periph_sel_o[IGP_LSB2 +: IGP_W2]),
      .irq_req_o(port_irq_o[2]), .irq_masked_o(masked[2]));

   // ------------------------------------------------------------------
   // bus checks
   // ------------------------------------------------------------------
   ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held two cycles");

   // every request is answered after exactly one wait state
   ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_o |=> ack_o)
      else $error("request not answered after one wait state");

   // registers are 16 bits; the upper half of the word stays quiet
   dat_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |-> dat_o[31:16] == 16'h0)
      else $error("upper read data not zero");

   // strobes are write only, a read of them returns zero
   strobe_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !ack_o && !we_i && (reg_idx == IGP_OUTPUT_SET_STROBE
         || reg_idx == IGP_OUTPUT_CLEAR_STROBE) |=> dat_o == 32'h0)
      else $error("strobe register read back nonzero");

   // the masked line never rises without a port request behind it
   irq_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o |-> port_irq_o != 3'h0)
      else $error("masked request without a port request");
endmodule : igp_top

// >>> tb/igp_pins_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// outside world at the pins
// ----------------------------------------------------------------------
module igp_pins_model (
   input wire logic [igp_pkg::IGP_PINS-1:0] drive_i,
   input wire logic [igp_pkg::IGP_PINS-1:0] drive_oe_i,
   input wire logic [igp_pkg::IGP_PINS-1:0] ext_i,
   output logic [igp_pkg::IGP_PINS-1:0] level_o
);
   import igp_pkg::*;
   // the block wins where it drives; the outside source takes the rest,
   // so an output pin also shows its own edges
   assign level_o = (drive_oe_i & drive_i) | (~drive_oe_i & ext_i);
endmodule : igp_pins_model

// >>> tb/test_interrupting_gpio_port.sv
`timescale 1ns/100ps
module test_interrupting_gpio_port;
   import igp_pkg::*;
   logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o;
   logic [IGP_ADR_W-1:0] adr_i;
   logic [31:0] dat_i, dat_o;
   logic [3:0] sel_i;
   logic [IGP_PINS-1:0] pin_i, pin_o, pin_oe_o, periph_out_i, periph_oe_i;
   logic [IGP_PINS-1:0] periph_sel_o, ext;
   logic [IGP_NPORTS-1:0] port_irq_o;
   logic [3:0] lanes = 4'h3;
   int fails, total_checks, c, d, pa, pb, da, db;
   int wid[3] = '{11, 15, 16};
   int lsb[3] = '{0, 11, 26};
   logic [15:0] base[3] = '{IGP_BASE0, IGP_BASE1, IGP_BASE2};
   // reference copy of each port's registers
   int dir[3], outv[3], fall[3], rise[3], pend[3], psel[3], mask[3], old[3];
   igp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .periph_out_i(periph_out_i),
      .periph_oe_i(periph_oe_i), .periph_sel_o(periph_sel_o),
      .port_irq_o(port_irq_o), .irq_o(irq_o));
   igp_pins_model i_pins (.drive_i(pin_o), .drive_oe_i(pin_oe_o),
      .ext_i(ext), .level_o(pin_i));
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic int wm(int p);
      return (1 << wid[p]) - 1;
   endfunction : wm
   function automatic logic [15:0] sl(logic [IGP_PINS-1:0] v, int p);
      return 16'(v >> lsb[p]) & 16'(wm(p));
   endfunction : sl
   function automatic int oe(int p);
      return (psel[p] & sl(periph_oe_i, p)) | (~psel[p] & dir[p]);
   endfunction : oe
   function automatic int lvl(int p);
      int drv;
      drv = (psel[p] & sl(periph_out_i, p)) | (~psel[p] & outv[p]);
      return ((oe(p) & drv) | (~oe(p) & sl(ext, p))) & wm(p);
   endfunction : lvl
   task automatic chk(string nm, int e, logic [15:0] g);
      total_checks++;
      if (g !== 16'(e)) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, 16'(e), g);
      end
   endtask : chk
   // classic single cycle, held until ack is sampled high
   task automatic wb(logic w, int p, int idx, int d, output logic [15:0] q);
      int n;
      @(posedge clk_i);
      adr_i <= {base[p] + 16'(idx), 2'b00};
      dat_i <= 32'(d) & 32'h0000ffff;
      we_i <= w;
      sel_i <= lanes;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o[15:0];
      chk("ack", 1, 16'(ack_o));
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(int p, int idx, int d);
      logic [15:0] t;
      wb(1'b1, p, idx, d, t);
   endtask : wr
   task automatic rdc(string nm, int p, int idx, int e);
      logic [15:0] t;
      wb(1'b0, p, idx, 0, t);
      chk(nm, e, t);
   endtask : rdc
   task automatic pins(int p);
      chk("pin_oe", oe(p), sl(pin_oe_o, p));
      chk("pin_out", lvl(p) & oe(p), sl(pin_o, p) & 16'(oe(p)));
      chk("periph_sel", psel[p], sl(periph_sel_o, p));
   endtask : pins
   task automatic irqs();
      logic [15:0] e;
      e = 16'h0000;
      for (int k = 0; k < 3; k++) begin
         e[k+1] = (pend[k] != 0);
         e[0] = e[0] | ((pend[k] & mask[k]) != 0);
      end
      chk("irq", e, 16'({port_irq_o, irq_o}));
   endtask : irqs
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // ------------------------------------------------------------------
   // clock and watchdog; the tests need well under 10k cycles
   // ------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      fails++;
      $display("mismatch watchdog expected done seen timeout");
      finish_test();
   end
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      {we_i, cyc_i, stb_i, adr_i, dat_i, sel_i} = '0;
      {ext, periph_out_i, periph_oe_i} = '0;
      fails = 0;
      total_checks = 0;
      c = $urandom(11);
      rst_i = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      for (int p = 0; p < 3; p++) begin
         for (int i = 0; i < 14; i++) rdc("reset", p, i, 0);
         pins(p);
      end
      $display("test reset done");
      for (int p = 0; p < 3; p++) begin
         dir[p] = $urandom;
         outv[p] = $urandom;
         wr(p, 0, dir[p]);
         wr(p, 1, outv[p]);
         dir[p] &= wm(p);
         outv[p] &= wm(p);
         ext <= IGP_PINS'({$urandom, $urandom});
         repeat (4) @(posedge clk_i);
         rdc("pin_direction", p, 0, dir[p]);
         rdc("output_value", p, 1, outv[p]);
         rdc("pin_level", p, 2, lvl(p));
         pins(p);
      end
      wr(2, 1, 16'hff00);
      wr(2, 6, 16'hf0f0);
      rdc("set_strobe", 2, 1, 16'hfff0);
      wr(2, 7, 16'hf0f0);
      outv[2] = 16'h0f00;
      rdc("clear_strobe", 2, 1, 16'h0f00);
      lanes = 4'h1;
      wr(2, 0, 16'h5aa5);
      lanes = 4'h3;
      dir[2] = (dir[2] & 16'hff00) | 16'h00a5;
      rdc("byte_lane", 2, 0, dir[2]);
      $display("test direction and output done");
      for (int p = 0; p < 3; p++) begin
         fall[p] = $urandom & wm(p);
         rise[p] = $urandom & wm(p);
         mask[p] = $urandom & wm(p);
         wr(p, 3, fall[p]);
         wr(p, 4, rise[p]);
         wr(p, 12, mask[p]);
      end
      for (int n = 0; n < 12; n++) begin
         for (int p = 0; p < 3; p++) old[p] = lvl(p);
         outv[n%3] = $urandom & wm(n%3);
         wr(n%3, 1, outv[n%3]);
         ext <= IGP_PINS'({$urandom, $urandom});
         repeat (5) @(posedge clk_i);
         for (int p = 0; p < 3; p++) begin
            d = lvl(p);
            pend[p] |= (rise[p] & ~old[p] & d) | (fall[p] & old[p] & ~d);
         end
         rdc("edge_pending", n%3, 5, pend[n%3]);
         irqs();
         c = $urandom & pend[n%3];
         wr(n%3, 5, c);
         pend[n%3] &= ~c;
         rdc("pend_clear", n%3, 5, pend[n%3]);
         irqs();
      end
      for (int p = 0; p < 3; p++) begin
         wr(p, 3, 0);
         wr(p, 4, 0);
         wr(p, 5, 16'hffff);
         {fall[p], rise[p], pend[p]} = '0;
      end
      irqs();
      $display("test edge capture done");
      for (int n = 0; n < 4; n++) begin
         {pa, pb, da, db} = {$urandom % 15, $urandom % 15, $urandom, $urandom};
         da &= 15;
         db &= 15;
         c = (db << 12) | (pb << 8) | (da << 4) | pa;
         wr(1, 8, c);
         rdc("bitmap_config", 1, 8, c);
         d = $urandom;
         wr(1, 9, d);
         outv[1] = (outv[1] & ~(1 << pa)) | (((d >> da) & 1) << pa);
         rdc("engine_a_write", 1, 1, outv[1]);
         d = $urandom;
         wr(1, 10, d);
         outv[1] = (outv[1] & ~(1 << pb)) | (((d >> db) & 1) << pb);
         rdc("engine_b_write", 1, 1, outv[1]);
         repeat (4) @(posedge clk_i);
         rdc("engine_a_read", 1, 9, ((lvl(1) >> pa) & 1) << da);
         rdc("engine_b_read", 1, 10, ((lvl(1) >> pb) & 1) << db);
      end
      $display("test bit engines done");
      periph_out_i <= IGP_PINS'({$urandom, $urandom});
      periph_oe_i <= IGP_PINS'({$urandom, $urandom});
      psel[0] = $urandom & wm(0);
      wr(0, 11, psel[0]);
      repeat (4) @(posedge clk_i);
      rdc("peripheral_select", 0, 11, psel[0]);
      rdc("periph_pin_level", 0, 2, lvl(0));
      pins(0);
      $display("test peripheral select done");
      finish_test();
   end
endmodule : test_interrupting_gpio_port
